/* File: rtl/cpg_regs.sv */
// clock source select and power-ok register bank with output logic
// assumes rail, thermal and reference-detect inputs are asynchronous analog flags
//
// Contract
// - loop enable clear forces internal oscillator, tracking loop off.
// - loop enable set runs loop in standby/active, uses external reference while reference detect is set.
// - with loop enabled, flag event on reference detect start and stop.
// - reference code is frequency minus one MHz, 0x00..0x17, resets 0x01; code stores any written 5-bit value, 0x18..0x1F included.
// - polarity bit chooses high or low level when rails valid.
// - drive bit chooses push-pull or open-drain output stage, resets one.
// - linear window bit chooses undervoltage only or full window check.
// - switcher window bit chooses undervoltage only or full window check.
// - per-rail watch bits include rails in monitoring.
// - thermal watch forces power-ok inactive during thermal warning.
// - fault gating bit selects live status or latched rail faults.
// - operating mode bit selects gated or continuous operation.
// - latch rail fault when watched rail drops; write one clears when valid.
// - latch drop event on active to inactive; write one clears.
`timescale 1ns/1ps
`default_nettype none
module cpg_regs
  import cpg_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire cpg_reg_access_type  reg_access,
  output logic [7:0]               reg_rdata,
  input  wire cpg_rail_status_type rail_status,
  input  wire logic                thermal_warning,
  input  wire logic                reference_present,
  input  wire logic                device_active,
  output logic                     tracking_loop_enable,
  output logic                     use_external_reference,
  output logic [4:0]               external_reference_frequency_code,
  output logic                     power_ok_output_o,
  output logic                     power_ok_output_oe_n,
  output logic                     power_ok_drive_type,
  output logic                     power_ok_operating_mode
);
  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic [7:0] clock_source_control_reg;
  logic [7:0] power_ok_control_one_reg;
  logic [7:0] power_ok_control_two_reg;
  logic [3:0] latched_rail_fault_reg;
  logic       drop_event_reg;
  logic       ref_event_reg;
  logic [10:0] in_meta_reg;
  logic [10:0] in_sync_reg;
  logic       ref_seen_reg;
  logic       valid_reg;
  logic [1:0] settle_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // two-stage sync of analog flags
  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      in_meta_reg <= 11'h000;
      in_sync_reg <= 11'h000;
    end else begin
      in_meta_reg <= {reference_present, thermal_warning, device_active, rail_status};
      in_sync_reg <= in_meta_reg;
    end
  end

  // startup guard: faults armed once the sync stages hold real samples
  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      settle_reg <= 2'b00;
    end else begin
      settle_reg <= {settle_reg[0], 1'b1};
    end
  end

  wire       armed       = settle_reg[1];
  wire [3:0] under_ok_s  = in_sync_reg[7:4];
  wire [3:0] over_ok_s   = in_sync_reg[3:0];
  wire       active_s    = in_sync_reg[8];
  wire       thermal_s   = in_sync_reg[9];
  wire       ref_s       = in_sync_reg[10];

  // address decode shared by reads and writes
  wire hit_clk = reg_access.addr == CLOCK_SOURCE_CONTROL_ADDR;
  wire hit_one = reg_access.addr == POWER_OK_CONTROL_ONE_ADDR;
  wire hit_two = reg_access.addr == POWER_OK_CONTROL_TWO_ADDR;
  wire hit_flt = reg_access.addr == LATCHED_RAIL_FAULT_ADDR;
  wire hit_evt = reg_access.addr == EVENT_STATUS_ADDR;

  wire wr_clk = reg_access.write_en && hit_clk;
  wire wr_one = reg_access.write_en && hit_one;
  wire wr_two = reg_access.write_en && hit_two;
  wire wr_flt = reg_access.write_en && hit_flt;
  wire wr_evt = reg_access.write_en && hit_evt;

  wire loop_on      = clock_source_control_reg[LOOP_ENABLE_BIT];
  wire [3:0] watch  = power_ok_control_one_reg[3:0];
  wire [3:0] window = {{2{power_ok_control_one_reg[LINEAR_WINDOW_BIT]}},
                       {2{power_ok_control_one_reg[SWITCHER_WINDOW_BIT]}}};

  wire [3:0] rail_pass;
  genvar g;
  generate
    for (g = 0; g < RAIL_COUNT; g++) begin : g_rail
      assign rail_pass[g] = under_ok_s[g] && (!window[g] || over_ok_s[g]);
    end
  endgenerate

  wire [3:0] rail_drop = watch & ~rail_pass;
  wire thermal_block = power_ok_control_two_reg[THERMAL_WATCH_BIT] && thermal_s;
  wire live_valid    = (rail_drop == 4'h0) && !thermal_block;
  wire valid_src  = power_ok_control_two_reg[FAULT_DRIVES_BIT]
                    ? (latched_rail_fault_reg == 4'h0) && !thermal_block
                    : live_valid;
  // held invalid until armed, so startup never looks like a drop
  wire valid_next = armed && valid_src;

  // fault set wins, clear only while rail output valid
  wire [3:0] fault_set   = armed ? rail_drop : 4'h0;
  wire [3:0] fault_clear = wr_flt ? (reg_access.wdata[3:0] & rail_pass) : 4'h0;
  wire [3:0] fault_next  = fault_set | (latched_rail_fault_reg & ~fault_clear);

  // drop event on active to inactive
  wire clear_drop = wr_evt && reg_access.wdata[DROP_EVENT_BIT];
  wire clear_ref  = wr_evt && reg_access.wdata[REF_CLOCK_EVENT_BIT];
  wire drop_seen  = valid_reg && !valid_next;
  wire drop_next  = drop_seen || (drop_event_reg && !clear_drop);

  wire ref_change = loop_on && (ref_s != ref_seen_reg);
  wire ref_next   = ref_change || (ref_event_reg && !clear_ref);

  // reserved bits held zero, code stored as written
  wire [7:0] clk_wdata = {1'b0, reg_access.wdata[LOOP_ENABLE_BIT], 1'b0,
                          reg_access.wdata[REF_CODE_MSB:0]};
  wire [7:0] two_wdata = {5'h00, reg_access.wdata[THERMAL_WATCH_BIT:0]};

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      clock_source_control_reg <= CLOCK_SOURCE_RESET;
      power_ok_control_one_reg <= POWER_OK_ONE_RESET;
      power_ok_control_two_reg <= POWER_OK_TWO_RESET;
      latched_rail_fault_reg   <= 4'h0;
      drop_event_reg           <= 1'b0;
      ref_event_reg            <= 1'b0;
      ref_seen_reg             <= 1'b0;
      valid_reg                <= 1'b0;
    end else begin
      if (wr_clk) begin
        clock_source_control_reg <= clk_wdata;
      end
      if (wr_one) begin
        power_ok_control_one_reg <= reg_access.wdata;
      end
      if (wr_two) begin
        power_ok_control_two_reg <= two_wdata;
      end
      latched_rail_fault_reg <= fault_next;
      drop_event_reg         <= drop_next;
      ref_event_reg          <= ref_next;
      ref_seen_reg           <= ref_s;
      valid_reg              <= valid_next;
    end
  end

  // read views of the status registers
  wire [7:0] fault_view = {4'h0, latched_rail_fault_reg};
  wire [7:0] event_view = {drop_event_reg, 2'b00, ref_event_reg, 4'h0};
  wire [7:0] rdata_next = hit_clk ? clock_source_control_reg :
                          hit_one ? power_ok_control_one_reg :
                          hit_two ? power_ok_control_two_reg :
                          hit_flt ? fault_view :
                          hit_evt ? event_view : 8'h00;

  wire polarity_low = power_ok_control_one_reg[POLARITY_BIT];
  wire open_drain   = power_ok_control_one_reg[DRIVE_TYPE_BIT];
  wire level_next   = valid_next ^ polarity_low;
  wire oe_n_next    = open_drain && level_next;
  // loop runs in standby or active only
  wire loop_active  = loop_on && active_s;
  wire ext_select   = loop_active && ref_s;

  always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata                         <= 8'h00;
      tracking_loop_enable              <= 1'b0;
      use_external_reference            <= 1'b0;
      external_reference_frequency_code <= CLOCK_SOURCE_RESET[REF_CODE_MSB:0];
      power_ok_output_o                 <= 1'b0;
      power_ok_output_oe_n              <= 1'b1;
      power_ok_drive_type               <= 1'b1;
      power_ok_operating_mode           <= 1'b0;
    end else begin
      reg_rdata <= reg_access.read_en ? rdata_next : 8'h00;
      tracking_loop_enable   <= loop_active;
      use_external_reference <= ext_select;
      external_reference_frequency_code <= clock_source_control_reg[REF_CODE_MSB:0];
      power_ok_output_o      <= level_next;
      power_ok_output_oe_n   <= oe_n_next;
      power_ok_drive_type    <= open_drain;
      power_ok_operating_mode <= power_ok_control_two_reg[OPERATING_MODE_BIT];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cpg_pkg.sv */
// package for the clock select and power-ok register bank
// assumes one system clock and an 8-bit register access port
package cpg_pkg;
  localparam logic [7:0] CLOCK_SOURCE_CONTROL_ADDR = 8'h14;
  localparam logic [7:0] POWER_OK_CONTROL_ONE_ADDR = 8'h15;
  localparam logic [7:0] POWER_OK_CONTROL_TWO_ADDR = 8'h16;
  localparam logic [7:0] LATCHED_RAIL_FAULT_ADDR   = 8'h17;
  localparam logic [7:0] EVENT_STATUS_ADDR         = 8'h19;
  localparam logic [7:0] CLOCK_SOURCE_RESET        = 8'h01;
  localparam logic [7:0] POWER_OK_ONE_RESET        = 8'h77;
  localparam logic [7:0] POWER_OK_TWO_RESET        = 8'h04;
  localparam int LOOP_ENABLE_BIT       = 6;
  localparam int REF_CODE_MSB          = 4;
  localparam int POLARITY_BIT          = 7;
  localparam int DRIVE_TYPE_BIT        = 6;
  localparam int LINEAR_WINDOW_BIT     = 5;
  localparam int SWITCHER_WINDOW_BIT   = 4;
  localparam int THERMAL_WATCH_BIT     = 2;
  localparam int FAULT_DRIVES_BIT      = 1;
  localparam int OPERATING_MODE_BIT    = 0;
  localparam int DROP_EVENT_BIT        = 7;
  localparam int REF_CLOCK_EVENT_BIT   = 4;
  localparam int RAIL_COUNT            = 4;
  localparam logic [4:0] REF_CODE_MAX  = 5'h17;

  // rail order: 0 switcher_zero, 1 switcher_one, 2 linear_reg_zero, 3 linear_reg_one
  typedef struct packed {
    logic [3:0] under_ok;
    logic [3:0] over_ok;
  } cpg_rail_status_type;

  typedef struct packed {
    logic       write_en;
    logic       read_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpg_reg_access_type;
endpackage

/* File: tb/cpg_regs_assertions.sv */
// port checker for the clock select and power-ok register bank
// assumes it is bound into cpg_regs and shares its clock and reset
`timescale 1ns/1ps
`default_nettype none
module cpg_regs_checker
  import cpg_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire cpg_reg_access_type reg_access,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reference_present,
  input wire logic               device_active,
  input wire logic               tracking_loop_enable,
  input wire logic               use_external_reference,
  input wire logic [4:0]         external_reference_frequency_code,
  input wire logic               power_ok_output_oe_n,
  input wire logic               power_ok_output_o,
  input wire logic               power_ok_drive_type
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire       wr_clk = reg_access.write_en && reg_access.addr == 8'h14;
  wire       rd_clk = reg_access.read_en && reg_access.addr == 8'h14;
  wire       rd_two = reg_access.read_en && reg_access.addr == 8'h16;
  wire [4:0] wr_code = reg_access.wdata[4:0];
  wire       wr_loop = reg_access.wdata[6];
  property p_rdata_idle; !reg_access.read_en |=> reg_rdata == 8'h00; endproperty
  property p_rsv_clk; rd_clk |=> reg_rdata[7] == 1'b0 && reg_rdata[5] == 1'b0; endproperty
  property p_rsv_two; rd_two |=> reg_rdata[7:3] == 5'h00; endproperty
  property p_code;
    wr_clk |=> ##1 external_reference_frequency_code == $past(wr_code, 2);
  endproperty
  property p_loop_off; wr_clk && !wr_loop |-> ##2 !tracking_loop_enable; endproperty
  property p_idle_dev; !device_active [*5] |-> !tracking_loop_enable; endproperty
  property p_ext_loop; use_external_reference |-> tracking_loop_enable; endproperty
  property p_no_ref; !reference_present [*5] |-> !use_external_reference; endproperty
  property p_open_drain;
    power_ok_drive_type && $stable(power_ok_drive_type) && power_ok_output_o
      |-> power_ok_output_oe_n;
  endproperty
  property p_push_pull;
    !power_ok_drive_type && $stable(power_ok_drive_type) |-> !power_ok_output_oe_n;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_rsv_clk: assert property (p_rsv_clk) else $error("reserved clock bits read one");
  a_rsv_two: assert property (p_rsv_two) else $error("reserved bits read one");
  a_code: assert property (p_code) else $error("reference code not stored");
  a_loop_off: assert property (p_loop_off) else $error("loop still on");
  a_idle_dev: assert property (p_idle_dev) else $error("loop on outside active");
  a_ext_loop: assert property (p_ext_loop) else $error("external use without loop");
  a_no_ref: assert property (p_no_ref) else $error("external use without ref");
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
  a_push_pull: assert property (p_push_pull) else $error("push pull not driving");
  c_wr_clk: cover property (wr_clk);
  c_ext: cover property (use_external_reference);
  c_drive: cover property (!power_ok_output_oe_n);
endmodule
bind cpg_regs cpg_regs_checker cpg_regs_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_access(reg_access), .reg_rdata(reg_rdata), .reference_present(reference_present),
  .device_active(device_active), .tracking_loop_enable(tracking_loop_enable),
  .use_external_reference(use_external_reference),
  .external_reference_frequency_code(external_reference_frequency_code),
  .power_ok_output_oe_n(power_ok_output_oe_n), .power_ok_output_o(power_ok_output_o),
  .power_ok_drive_type(power_ok_drive_type));
`default_nettype wire

/* File: tb/tb_cpg_regs.sv */
// self-checking bench for the clock select and power-ok register bank
// assumes a 40 MHz clock; inputs change 2 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_cpg_regs
  import cpg_pkg::*;
;
  logic                clk_sys, rst_n, thermal_warning, reference_present, device_active;
  logic                loop_on, ext_ref, pok_level, pok_oe_n, pok_drive, pok_mode;
  logic [7:0]          rdata;
  logic [4:0]          ref_code;
  cpg_reg_access_type  acc;
  cpg_rail_status_type rails;
  int                  n_mismatch = 0, total_checks = 0, cycles = 0;
  cpg_regs cpg_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_access(acc),
    .reg_rdata(rdata), .rail_status(rails), .thermal_warning(thermal_warning),
    .reference_present(reference_present), .device_active(device_active),
    .tracking_loop_enable(loop_on), .use_external_reference(ext_ref),
    .external_reference_frequency_code(ref_code), .power_ok_output_o(pok_level),
    .power_ok_output_oe_n(pok_oe_n), .power_ok_drive_type(pok_drive),
    .power_ok_operating_mode(pok_mode));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc = '{1'b1, 1'b0, a, d};
    wt(1);
    acc.write_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc = '{1'b0, 1'b1, a, 8'h00};
    wt(1);
    acc.read_en = 1'b0;
    check(rdata, exp);
  endtask
  task automatic pk(input logic o, input logic oe_n);
    wt(5);
    check({6'h00, pok_level, pok_oe_n}, {6'h00, o, oe_n});
  endtask
  initial begin
    rst_n = 1'b0;
    acc = '0;
    rails = '{4'h7, 4'hF};
    thermal_warning = 1'b0;
    reference_present = 1'b0;
    device_active = 1'b0;
    repeat (20) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    wt(3);
    rd(8'h14, 8'h01);
    rd(8'h15, 8'h77);
    rd(8'h16, 8'h04);
    rd(8'h30, 8'h00);
    check({7'h00, pok_drive}, 8'h01);
    pk(1'b1, 1'b1);
    $display("reset test done");
    wr(8'h14, 8'hD7);
    rd(8'h14, 8'h57);
    check({3'h0, ref_code}, 8'h17);
    device_active = 1'b1;
    reference_present = 1'b1;
    wt(5);
    check({6'h00, loop_on, ext_ref}, 8'h03);
    rd(8'h19, 8'h10);
    wr(8'h19, 8'h10);
    reference_present = 1'b0;
    wt(5);
    check({6'h00, loop_on, ext_ref}, 8'h02);
    rd(8'h19, 8'h10);
    wr(8'h19, 8'h10);
    wr(8'h14, 8'h00);
    reference_present = 1'b1;
    wt(5);
    check({6'h00, loop_on, ext_ref}, 8'h00);
    rd(8'h19, 8'h00);
    $display("clock test done");
    wr(8'h15, 8'h37);
    pk(1'b1, 1'b0);
    check({7'h00, pok_drive}, 8'h00);
    wr(8'h15, 8'hB7);
    pk(1'b0, 1'b0);
    rails.over_ok[2] = 1'b0;
    pk(1'b1, 1'b0);
    rd(8'h19, 8'h80);
    rd(8'h17, 8'h04);
    wr(8'h15, 8'h97);
    pk(1'b0, 1'b0);
    rails.over_ok[2] = 1'b1;
    wt(4);
    wr(8'h17, 8'h04);
    wr(8'h19, 8'h80);
    rd(8'h17, 8'h00);
    rd(8'h19, 8'h00);
    thermal_warning = 1'b1;
    pk(1'b1, 1'b0);
    wr(8'h16, 8'h00);
    pk(1'b0, 1'b0);
    thermal_warning = 1'b0;
    wr(8'h15, 8'h9F);
    pk(1'b1, 1'b0);
    wr(8'h15, 8'h97);
    wr(8'h16, 8'h03);
    pk(1'b1, 1'b0);
    check({7'h00, pok_mode}, 8'h01);
    rails.under_ok[3] = 1'b1;
    wt(4);
    wr(8'h17, 8'h08);
    pk(1'b0, 1'b0);
    $display("power test done");
    give_verdict();
  end
endmodule
`default_nettype wire
